// [src/analog_control_pwm_pkg.sv]
package analog_control_pwm_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the special-function bus
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LEVEL_CH0    = 8'hE4;
    localparam logic [7:0] ADDR_LEVEL_CH1    = 8'hE5;
    localparam logic [7:0] ADDR_LEVEL_CH2    = 8'hE6;
    localparam logic [7:0] ADDR_LEVEL_CH3    = 8'hE7;
    localparam logic [7:0] ADDR_LEVEL_CH4    = 8'hEC;
    localparam logic [7:0] ADDR_LEVEL_CH5    = 8'hED;
    localparam logic [7:0] ADDR_LEVEL_CH6    = 8'hEE;
    localparam logic [7:0] ADDR_LEVEL_CH7    = 8'hEF;
    localparam logic [7:0] ADDR_TUNING_LOWER = 8'hD2;
    localparam logic [7:0] ADDR_TUNING_UPPER = 8'hD3;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_CHANNELS     = 8;
    localparam int          CH_SELECT_BIT    = 7;
    localparam int          TUNE_SELECT_BIT  = 7;
    localparam logic [7:0]  UPPER_RW_MASK    = 8'hBF;
    localparam logic [7:0]  LEVEL_RESET      = 8'h00;
    localparam logic [7:0]  TUNING_RESET     = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          OSC_PER_TICK     = 4;
    localparam int          CH_REPEAT_OSC    = 512;
    localparam int          CH_REPEAT_TICKS  = CH_REPEAT_OSC / OSC_PER_TICK;
    localparam int          SUBPERIOD_TICKS  = 128;
    localparam int          FULL_CYCLE_TICKS = 16384;
    localparam logic [1:0]  PRESCALE_LAST    = 2'(OSC_PER_TICK - 1);
    localparam logic [6:0]  POS_LAST         = 7'(SUBPERIOD_TICKS - 1);
    localparam logic [7:0]  COARSE_THRESHOLD = 8'(SUBPERIOD_TICKS);

endpackage : analog_control_pwm_pkg

// [src/analog_control_pwm.sv]
// Operation
// - Channel pin carries pulse when its select bit 7 is one, else port.
// - Channels tick at quarter oscillator; pattern repeats every 128 ticks.
// - Channel outputs are always active high, never inverted.
// - Channel high time equals its 7-bit value in ticks.
// - Channel rising edges are staggered one tick apart.
// - Channel one rises at count 2, channel five at count 6.
// - Tuning output is active high with 16384 levels from latches.
// - Tuning select bit 7 of upper latch chooses pulse or port line.
// - Working register loads at first subperiod start after upper write.
// - New tuning pattern appears one subperiod after the load.
// - Upper seven working bits are coarse, lower seven are fine.
// - Tuning output is coarse OR fine pulse output.
// - 14-bit counter runs continuously at quarter oscillator rate.
// - Subperiod is 128 ticks; full cycle 16384 ticks.
// - Coarse pulse absent in subperiod zero, present in all others unless value is zero.
// - Coarse low for 128 minus value ticks then high to end.
// - Coarse zero stays low; maximum gives one low then 127 high.
// - Fine pulse is one tick wide at start of selected subperiod.
// - Fine value picks both subperiods and pulse count.
// - Fine pulse count per cycle equals fine value, spread evenly.
// - Fine bit 0 picks 64, bit 1 32 and 96, bit 6 odd.
// - Upper latch: select bit 7, bits 13..8 in 5..0; lower bits 7..0.
`timescale 1ns/1ps
`default_nettype none

module analog_control_pwm
    import analog_control_pwm_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_rst_n,
    // Special-function register port
    input  wire logic [7:0]              i_sfr_addr,
    input  wire logic [7:0]              i_sfr_wdata,
    input  wire logic                    i_sfr_wr,
    input  wire logic                    i_sfr_rd,
    output logic      [7:0]              o_sfr_rdata,
    // Port latch values of the shared pins
    input  wire logic [NUM_CHANNELS-1:0] i_channel_port,
    input  wire logic                    i_tuning_port,
    // Pin levels and function selects
    output logic      [NUM_CHANNELS-1:0] o_channel_pin,
    output logic      [NUM_CHANNELS-1:0] o_channel_pin_select,
    output logic                         o_tuning_pin,
    output logic                         o_tuning_pin_select,
    // Raw pulse outputs
    output logic      [NUM_CHANNELS-1:0] o_channel_level_pulse,
    output logic                         o_tuning_output
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // The two channel groups sit in two contiguous address runs
    function automatic logic [7:0] addr_of_channel(input int ch);
        return (ch < 4) ? ADDR_LEVEL_CH0 + 8'(ch)
                        : ADDR_LEVEL_CH4 + 8'(ch - 4);
    endfunction : addr_of_channel

    // Lowest set bit of the subperiod index picks one fine bit; bit k
    // serves the subperiods whose index has 6-k trailing zeros.
    function automatic logic fine_selects(input logic [6:0] sub,
                                          input logic [6:0] fine);
        for (int j = 0; j < 7; j++)
        begin
            if (sub[j])
            begin
                return fine[6-j];
            end
        end
        return 1'b0;
    endfunction : fine_selects

    // ------------------------------------------------------------------
    // Quarter-oscillator tick
    // ------------------------------------------------------------------
    logic [1:0] prescale;
    logic       tick;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prescale <= 2'h0;
        end
        else
        begin
            prescale <= (prescale == PRESCALE_LAST) ? 2'h0 : prescale + 2'h1;
        end
    end

    assign tick = (prescale == PRESCALE_LAST);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] channel_level_value [NUM_CHANNELS];
    logic [7:0] tuning_lower_latch;
    logic [7:0] tuning_upper_latch;
    logic       wr_upper;

    assign wr_upper = i_sfr_wr && (i_sfr_addr == ADDR_TUNING_UPPER);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int n = 0; n < NUM_CHANNELS; n++)
            begin
                channel_level_value[n] <= LEVEL_RESET;
            end
        end
        else
        begin
            for (int n = 0; n < NUM_CHANNELS; n++)
            begin
                if (i_sfr_wr && (i_sfr_addr == addr_of_channel(n)))
                begin
                    channel_level_value[n] <= i_sfr_wdata;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tuning_lower_latch <= TUNING_RESET;
            tuning_upper_latch <= TUNING_RESET;
        end
        else
        begin
            if (i_sfr_wr && (i_sfr_addr == ADDR_TUNING_LOWER))
            begin
                tuning_lower_latch <= i_sfr_wdata;
            end
            if (wr_upper)
            begin
                tuning_upper_latch <= i_sfr_wdata & UPPER_RW_MASK;
            end
        end
    end

    // Read data is registered; unused bit 6 of the upper latch reads 0
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sfr_rdata <= UNMAPPED_READ;
        end
        else if (i_sfr_rd)
        begin
            o_sfr_rdata <= UNMAPPED_READ;
            if (i_sfr_addr == ADDR_TUNING_LOWER)
            begin
                o_sfr_rdata <= tuning_lower_latch;
            end
            if (i_sfr_addr == ADDR_TUNING_UPPER)
            begin
                o_sfr_rdata <= tuning_upper_latch;
            end
            for (int n = 0; n < NUM_CHANNELS; n++)
            begin
                if (i_sfr_addr == addr_of_channel(n))
                begin
                    o_sfr_rdata <= channel_level_value[n];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Low-resolution channels
    // ------------------------------------------------------------------
    // One free-running base count; each channel's own counter is the base
    // offset by its stagger, so no channel can drift from the others.
    logic [6:0] base_count;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            base_count <= 7'h00;
        end
        else if (tick)
        begin
            base_count <= base_count + 7'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_channel_level_pulse <= '0;
        end
        else
        begin
            for (int n = 0; n < NUM_CHANNELS; n++)
            begin
                // Active high only; no inversion path exists
                o_channel_level_pulse[n] <= (7'(base_count - 7'(n + 1))
                    < channel_level_value[n][6:0]);
            end
        end
    end

    always_comb
    begin
        for (int n = 0; n < NUM_CHANNELS; n++)
        begin
            o_channel_pin_select[n] = channel_level_value[n][CH_SELECT_BIT];
            o_channel_pin[n] = o_channel_pin_select[n] ?
                o_channel_level_pulse[n] : i_channel_port[n];
        end
    end

    // ------------------------------------------------------------------
    // Tuning time base
    // ------------------------------------------------------------------
    logic [13:0] tuning_count;
    logic [6:0]  subperiod;
    logic [6:0]  position;
    logic        sub_start;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tuning_count <= 14'h0000;
        end
        else if (tick)
        begin
            tuning_count <= tuning_count + 14'h0001;
        end
    end

    assign subperiod = tuning_count[13:7];
    assign position  = tuning_count[6:0];
    // Last clock before a new subperiod begins
    assign sub_start = tick && (position == POS_LAST);

    // ------------------------------------------------------------------
    // Tuning load pipeline
    // ------------------------------------------------------------------
    // Software must fill the lower latch first; the upper write arms the
    // load. A write landing on the boundary keeps the request armed.
    logic        load_pending;
    logic [13:0] tuning_working_register;
    logic        stage_pending;
    logic [6:0]  coarse_value;
    logic [6:0]  fine_value;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_pending <= 1'b0;
        end
        else if (wr_upper)
        begin
            load_pending <= 1'b1;
        end
        else if (sub_start)
        begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tuning_working_register <= 14'h0000;
            stage_pending           <= 1'b0;
        end
        else if (sub_start)
        begin
            stage_pending <= load_pending && !wr_upper;
            if (load_pending && !wr_upper)
            begin
                tuning_working_register <=
                    {tuning_upper_latch[5:0], tuning_lower_latch};
            end
        end
    end

    // The pattern values follow the working register one subperiod later
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            coarse_value <= 7'h00;
            fine_value   <= 7'h00;
        end
        else if (sub_start && stage_pending)
        begin
            coarse_value <= tuning_working_register[13:7];
            fine_value   <= tuning_working_register[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Coarse and fine controllers and mixer
    // ------------------------------------------------------------------
    logic coarse_pulse_out;
    logic fine_pulse_out;

    // High once position + value reaches 128, i.e. the last value ticks
    assign coarse_pulse_out = (subperiod != 7'h00)
        && (8'(position) + 8'(coarse_value) >= COARSE_THRESHOLD);

    assign fine_pulse_out = (position == 7'h00)
        && fine_selects(subperiod, fine_value);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_tuning_output <= 1'b0;
        end
        else
        begin
            o_tuning_output <= coarse_pulse_out | fine_pulse_out;
        end
    end

    assign o_tuning_pin_select = tuning_upper_latch[TUNE_SELECT_BIT];
    assign o_tuning_pin = o_tuning_pin_select ?
        o_tuning_output : i_tuning_port;

endmodule : analog_control_pwm

`default_nettype wire

// [testbench/analog_control_pwm_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module analog_control_pwm_sva
    import analog_control_pwm_pkg::*;
(
    // Clock, reset and register port
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic       i_sfr_wr,
    input wire logic       i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    // Pins
    input wire logic [7:0] i_channel_port,
    input wire logic       i_tuning_port,
    input wire logic [7:0] o_channel_pin,
    input wire logic [7:0] o_channel_pin_select,
    input wire logic       o_tuning_pin,
    input wire logic       o_tuning_pin_select,
    input wire logic [7:0] o_channel_level_pulse,
    input wire logic       o_tuning_output
);
    // ----------------
    // Phase tracking
    // ----------------
    // A level write may cause one off-phase rise, so only rises in
    // quiet time feed the phase reference.
    logic [8:0] fc;
    logic [8:0] ph0;
    logic [8:0] gap;
    logic [3:0] wc;
    logic [6:0] lvl0;
    logic       v0;
    wire logic  p0 = o_channel_level_pulse[0];
    wire logic  quiet = wc > 4'h7;
    wire logic  lvl_wr = i_sfr_wr && i_sfr_addr[7:4] == 4'hE && i_sfr_addr[2];

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fc   <= '0;
            ph0  <= '0;
            gap  <= '0;
            wc   <= '0;
            lvl0 <= '0;
            v0   <= 1'h0;
        end
        else
        begin
            fc  <= fc + 9'h1;
            gap <= ($rose(p0) && quiet) ? 9'h1 : gap + 9'h1;
            wc  <= lvl_wr ? 4'h0 : wc + 4'(wc != 4'hF);
            if ($rose(p0) && quiet)
            begin
                ph0 <= fc;
                v0  <= 1'h1;
            end
            if (i_sfr_wr && i_sfr_addr == ADDR_LEVEL_CH0)
                lvl0 <= i_sfr_wdata[6:0];
        end
    end

    // ----------------
    // Assertions
    // ----------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_rd_upper;
        i_sfr_rd && i_sfr_addr == ADDR_TUNING_UPPER;
    endsequence
    property p_ch_mux;
        o_channel_pin == ((o_channel_pin_select & o_channel_level_pulse)
            | (~o_channel_pin_select & i_channel_port));
    endproperty
    a_ch_mux: assert property (p_ch_mux) else $error("channel pin");
    property p_tune_mux;
        o_tuning_pin == (o_tuning_pin_select ? o_tuning_output : i_tuning_port);
    endproperty
    a_tune_mux: assert property (p_tune_mux) else $error("tuning pin");
    property p_ch5_sel;
        i_sfr_wr && i_sfr_addr == ADDR_LEVEL_CH5
            |=> o_channel_pin_select[5] == $past(i_sfr_wdata[7]);
    endproperty
    a_ch5_sel: assert property (p_ch5_sel) else $error("select bit");
    property p_period;
        $rose(p0) && quiet && v0 |-> gap == 9'h0;
    endproperty
    a_period: assert property (p_period) else $error("period");
    property p_stagger1;
        $rose(o_channel_level_pulse[1]) && quiet && v0 |-> fc - ph0 == 9'h4;
    endproperty
    a_stagger1: assert property (p_stagger1) else $error("ch1 start");
    property p_stagger5;
        $rose(o_channel_level_pulse[5]) && quiet && v0 |-> fc - ph0 == 9'h14;
    endproperty
    a_stagger5: assert property (p_stagger5) else $error("ch5 start");
    property p_zero;
        lvl0 == 7'h0 && $past(lvl0) == 7'h0 |-> !p0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero level high");
    property p_rd_bit6;
        s_rd_upper |=> !o_sfr_rdata[6];
    endproperty
    a_rd_bit6: assert property (p_rd_bit6) else $error("unused bit");
endmodule : analog_control_pwm_sva

bind analog_control_pwm analog_control_pwm_sva i_sva (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .i_channel_port(i_channel_port),
    .i_tuning_port(i_tuning_port), .o_channel_pin(o_channel_pin),
    .o_channel_pin_select(o_channel_pin_select),
    .o_tuning_pin(o_tuning_pin),
    .o_tuning_pin_select(o_tuning_pin_select),
    .o_channel_level_pulse(o_channel_level_pulse),
    .o_tuning_output(o_tuning_output)
);

`default_nettype wire

// [testbench/pin_integrator_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Sums high clocks and rising edges, the quantity an RC network averages
module pin_integrator_model
(
    // Clock and window clear
    input  wire logic  i_clock,
    input  wire logic  i_clear,
    // Pin and integrated results
    input  wire logic  i_pin,
    output var integer o_high,
    output var integer o_rises
);
    logic last;

    always @(posedge i_clock)
    begin
        last <= i_pin;
        // Four-state sums so an unknown pin level poisons the result
        o_high  <= i_clear ? 32'h0 : o_high + {31'h0, i_pin};
        o_rises <= i_clear ? 32'h0 : o_rises + {31'h0, i_pin && !last};
    end
endmodule : pin_integrator_model

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import analog_control_pwm_pkg::*;
;
    logic       clock;
    logic       rst_n;
    logic       wr;
    logic       rd;
    logic       t_port;
    logic       clr;
    logic       t_pin;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] c_port;
    logic [7:0] c_pin;
    logic [7:0] c_sel;
    logic [7:0] c_pulse;
    integer     c_high;
    integer     c_rises;
    integer     t_high;
    integer     t_rises;
    int         n_errors;
    int         n_tests;

    analog_control_pwm i_dut (
        .i_clock(clock), .i_rst_n(rst_n), .i_sfr_addr(addr),
        .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .o_sfr_rdata(rdata), .i_channel_port(c_port),
        .i_tuning_port(t_port), .o_channel_pin(c_pin),
        .o_channel_pin_select(c_sel), .o_tuning_pin(t_pin),
        .o_tuning_pin_select(), .o_channel_level_pulse(c_pulse),
        .o_tuning_output()
    );
    pin_integrator_model i_c_net (.i_clock(clock), .i_clear(clr),
        .i_pin(c_pin[0]), .o_high(c_high), .o_rises(c_rises));
    pin_integrator_model i_t_net (.i_clock(clock), .i_clear(clr),
        .i_pin(t_pin), .o_high(t_high), .o_rises(t_rises));

    // ----------------
    // Bus and compare tasks
    // ----------------
    task automatic check8(input string what, input logic [7:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error: %s expected %h seen %h", what, e, g);
        end
    endtask : check8
    task automatic check_n(input string what, input integer e, g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error: %s expected %0d seen %0d", what, e, g);
        end
    endtask : check_n
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clock);
        wr    <= 1'h0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock);
        rd   <= 1'h0;
        @(negedge clock);
        d = rdata;
    endtask : rd_reg
    // Window of n clocks on both integrators
    task automatic measure(input int n);
        @(posedge clock);
        clr <= 1'h1;
        @(posedge clock);
        clr <= 1'h0;
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : measure
    function automatic logic [7:0] ch_addr(input int k);
        return k < 4 ? ADDR_LEVEL_CH0 + 8'(k) : ADDR_LEVEL_CH4 + 8'(k - 4);
    endfunction : ch_addr

    // ----------------
    // Scenarios
    // ----------------
    task automatic test_registers();
        logic [7:0] d;
        t_port <= 1'h1;
        for (int k = 0; k < 8; k++)
            wr_reg(ch_addr(k), {k[0], 7'(k * 9 + 3)});
        for (int k = 0; k < 8; k++)
        begin
            rd_reg(ch_addr(k), d);
            check8("level reg", {k[0], 7'(k * 9 + 3)}, d);
        end
        check8("selects", 8'hAA, c_sel);
        rd_reg(8'h00, d);
        check8("unmapped", UNMAPPED_READ, d);
        wr_reg(ADDR_TUNING_UPPER, 8'hFF);
        rd_reg(ADDR_TUNING_UPPER, d);
        check8("tuning upper", 8'hFF & UPPER_RW_MASK, d);
        check8("tuning pin", 8'h00, {7'h0, t_pin});
        wr_reg(ADDR_TUNING_UPPER, 8'h00);
        @(negedge clock);
        check8("tuning port", 8'h01, {7'h0, t_pin});
        $display("test_registers done");
    endtask : test_registers
    task automatic test_channel();
        int v[4] = '{0, 1, 5, 127};
        foreach (v[i])
        begin
            wr_reg(ch_addr(0), 8'h80 | 8'(v[i]));
            repeat (CH_REPEAT_OSC) @(posedge clock);
            measure(CH_REPEAT_OSC);
            check_n("high clocks", OSC_PER_TICK * v[i], c_high);
            check_n("rises", int'(v[i] != 0), c_rises);
        end
        wr_reg(ch_addr(0), 8'h05);
        c_port <= 8'hFF;
        measure(CH_REPEAT_OSC);
        check_n("port mode", CH_REPEAT_OSC, c_high);
        @(posedge clock);
        c_port <= 8'h00;
        $display("test_channel done");
    endtask : test_channel
    task automatic test_stagger();
        int         t0;
        int         rt[8];
        logic [7:0] prev;
        for (int k = 0; k < 8; k++)
            wr_reg(ch_addr(k), 8'h81);
        t0 = -1;
        rt = '{default: -1};
        @(negedge clock);
        prev = c_pulse;
        for (int t = 0; t < 600; t++)
        begin
            @(negedge clock);
            for (int k = 0; k < 8; k++)
                if (c_pulse[k] && !prev[k] && t0 >= 0 && rt[k] < 0)
                    rt[k] = t - t0;
            if (c_pulse[0] && !prev[0] && t0 < 0)
                t0 = t;
            prev = c_pulse;
        end
        for (int k = 1; k < 8; k++)
            check_n("rise offset", OSC_PER_TICK * k, rt[k]);
        $display("test_stagger done");
    endtask : test_stagger
    task automatic test_tuning();
        logic [13:0] w;
        int          e;
        // Fine bits 0, 1 and 3: every extra pulse joins a coarse pulse
        w = {6'h0E, 8'h8B};
        e = (FULL_CYCLE_TICKS / SUBPERIOD_TICKS - 1) * int'(w[13:7]);
        e = OSC_PER_TICK * (e + int'(w[6:0]));
        wr_reg(ADDR_TUNING_LOWER, w[7:0]);
        wr_reg(ADDR_TUNING_UPPER, {2'h2, w[13:8]});
        // Load, one subperiod of latency, then margin
        repeat (3 * SUBPERIOD_TICKS * OSC_PER_TICK) @(posedge clock);
        measure(FULL_CYCLE_TICKS * OSC_PER_TICK);
        check_n("tuning high", e, t_high);
        check_n("coarse pulses", SUBPERIOD_TICKS - 1, t_rises);
        $display("test_tuning done");
    endtask : test_tuning
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        {rst_n, wr, rd, t_port, clr} = 5'h0;
        {addr, wdata, c_port} = 24'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        test_registers();
        test_channel();
        test_stagger();
        test_tuning();
        test_done();
    end
    // About 73000 clocks are needed; stop well beyond that
    initial
    begin
        repeat (90000) @(posedge clock);
        n_errors++;
        $display("Error: run time expected end seen timeout");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
